// ==== rtl/osr_defs.svh ====
/*
 Constants of the operation status reporting block: bit positions,
 widths, reset values. Assumes nothing beyond a preprocessor.
*/
`ifndef OSR_DEFS_SVH
`define OSR_DEFS_SVH
`define OSR_COND_W 16
`define OSR_WAIT_ARM_BIT 6
`define OSR_STB_OPER_BIT 7
`define OSR_PTR_RESET 16'hffff
`define OSR_NTR_RESET 16'h0000
`define OSR_ENAB_RESET 16'h0000
`define OSR_LEVEL_W 12
`define OSR_LEVEL_RESET 12'h000
`endif

// ==== rtl/osr_pkg.sv ====
/*
 Types of the operation status reporting block.
 Assumes osr_defs.svh is on the include path.
*/
`include "osr_defs.svh"
package osr_pkg;
	typedef enum logic [1:0] {
		OSR_IDLE,
		OSR_WAIT_ARM,
		OSR_WAIT_TRIG
	} osr_state_type;
	typedef enum logic {
		OSR_ARM_EXT,
		OSR_ARM_LEVEL
	} osr_arm_src_type;
endpackage

// ==== rtl/osr_sync.sv ====
/*
 Two-flop synchroniser for one level from outside the clock domain.
 Assumes one clock, synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module osr_sync (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic async_in,
	output logic sync_out
);
	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;

	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;
endmodule
`default_nettype wire

// ==== rtl/osr_top.sv ====
/*
 Operation status group of a digitizer: condition, transition filter,
 sticky events, enable mask, status byte summary, and the arm/trigger
 sequencing that drives the wait-for-arm condition.
 Assumes a command processor (text or opcode path) presents writes and
 commands as one-cycle pulses on mclk_in; the arm pin and the input
 comparator are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "osr_defs.svh"
// How it works
// - Initiate raises wait-for-arm condition bit 6
// - Arm received while waiting drops condition bit 6
// - Reset: rising-edge mask all ones, falling-edge mask all zeros
// - Separate writable rising and falling transition masks, 16 bits each
// - Selected edge sets its event bit high, whatever its direction
// - Events AND enable mask, ORed into operation summary bit
// - Enabled event sets status byte bit 7, new events only, either direction
// - Level arm source arms on rising edge of the synchronised comparator input; arm_level_in is not used
// - Held trigger: no sample until immediate trigger command
// - Control by translated text commands or direct opcode writes
module osr_top
	import osr_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic host_sel_in,
	input wire logic msg_wr_in,
	input wire logic [1:0] msg_addr_in,
	input wire logic [15:0] msg_data_in,
	input wire logic reg_wr_in,
	input wire logic [1:0] reg_addr_in,
	input wire logic [15:0] reg_data_in,
	input wire logic init_in,
	input wire logic trig_imm_in,
	input wire logic clear_in,
	input wire logic event_rd_in,
	input wire logic stb_rd_in,
	input wire logic arm_src_level_in,
	input wire logic trig_hold_in,
	input wire logic [`OSR_LEVEL_W-1:0] arm_level_in,
	input wire logic ext_arm_in,
	input wire logic input_level_arm_source_in,
	output logic [15:0] condition_out,
	output logic [15:0] event_out,
	output logic [7:0] status_byte_out,
	output logic sample_out
);
	// Write address map of the mask registers
	localparam logic [1:0] ADDR_PTR = 2'h0;
	localparam logic [1:0] ADDR_NTR = 2'h1;
	localparam logic [1:0] ADDR_ENAB = 2'h2;

	logic arm_pin_s;
	logic level_above_s;
	logic level_above_q;
	logic level_above_d;
	osr_state_type state_q;
	osr_state_type state_d;
	logic [15:0] cond_q;
	logic [15:0] cond_d;
	logic [15:0] ptr_q;
	logic [15:0] ptr_d;
	logic [15:0] ntr_q;
	logic [15:0] ntr_d;
	logic [15:0] enab_q;
	logic [15:0] enab_d;
	logic [15:0] event_q;
	logic [15:0] event_d;
	logic [7:0] stb_q;
	logic [7:0] stb_d;
	logic sample_q;
	logic sample_d;
	logic wr;
	logic [1:0] waddr;
	logic [15:0] wdata;
	logic arm;
	logic [15:0] hits;
	logic oper_sum;

	// Pins cross into the clock domain before any logic sees them
	osr_sync u_sync_arm (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.async_in(ext_arm_in),
		.sync_out(arm_pin_s)
	);
	osr_sync u_sync_lvl (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.async_in(input_level_arm_source_in),
		.sync_out(level_above_s)
	);

	always_comb begin
		wr = host_sel_in ? reg_wr_in : msg_wr_in;
		waddr = host_sel_in ? reg_addr_in : msg_addr_in;
		wdata = host_sel_in ? reg_data_in : msg_data_in;
		level_above_d = level_above_s;
		if (arm_src_level_in) begin
			arm = level_above_s && !level_above_q;
		end else begin
			arm = arm_pin_s;
		end
	end

	always_comb begin
		state_d = state_q;
		sample_d = 1'b0;
		case (state_q)
			OSR_IDLE: begin
				if (init_in) begin
					state_d = OSR_WAIT_ARM;
				end
			end
			OSR_WAIT_ARM: begin
				if (arm) begin
					state_d = OSR_WAIT_TRIG;
				end
			end
			OSR_WAIT_TRIG: begin
				if (!trig_hold_in || trig_imm_in) begin
					sample_d = 1'b1;
					state_d = OSR_IDLE;
				end
			end
			default: state_d = OSR_IDLE;
		endcase
		cond_d = 16'h0000;
		cond_d[`OSR_WAIT_ARM_BIT] = (state_d == OSR_WAIT_ARM);
	end

	always_comb begin
		ptr_d = ptr_q;
		ntr_d = ntr_q;
		enab_d = enab_q;
		if (wr) begin
			if (waddr == ADDR_PTR) begin
				ptr_d = wdata;
			end else if (waddr == ADDR_NTR) begin
				ntr_d = wdata;
			end else if (waddr == ADDR_ENAB) begin
				enab_d = wdata;
			end
		end
		hits = (ptr_q & cond_d & ~cond_q) | (ntr_q & ~cond_d & cond_q);
		// cleared only by read or clear; set wins
		event_d = ((clear_in || event_rd_in) ? 16'h0000 : event_q) | hits;
		// enabled summary
		// New enabled events only, so a status read is not undone
		oper_sum = |(hits & enab_q);
		stb_d = (clear_in || stb_rd_in) ? 8'h00 : stb_q;
		if (oper_sum) begin
			stb_d[`OSR_STB_OPER_BIT] = 1'b1;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			state_q <= OSR_IDLE;
			cond_q <= 16'h0000;
			ptr_q <= `OSR_PTR_RESET;
			ntr_q <= `OSR_NTR_RESET;
			enab_q <= `OSR_ENAB_RESET;
			event_q <= 16'h0000;
			stb_q <= 8'h00;
			sample_q <= 1'b0;
			level_above_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cond_q <= cond_d;
			ptr_q <= ptr_d;
			ntr_q <= ntr_d;
			enab_q <= enab_d;
			event_q <= event_d;
			stb_q <= stb_d;
			sample_q <= sample_d;
			level_above_q <= level_above_d;
		end
	end

	assign condition_out = cond_q;
	assign event_out = event_q;
	assign status_byte_out = stb_q;
	assign sample_out = sample_q;

	// Assertions
	a_cond_rise: assert property (@(posedge mclk_in) disable iff (rst_in)
		(state_q == OSR_IDLE && init_in) |=> condition_out[6])
		else $error("wait-for-arm bit not raised");
	a_cond_fall: assert property (@(posedge mclk_in) disable iff (rst_in)
		(state_q == OSR_WAIT_ARM && arm) |=> !condition_out[6])
		else $error("wait-for-arm bit not dropped");
	a_reset_masks: assert property (@(posedge mclk_in)
		$past(rst_in) |-> (ptr_q == 16'hffff && ntr_q == 16'h0000))
		else $error("mask reset values wrong");
	a_mask_write: assert property (@(posedge mclk_in) disable iff (rst_in)
		(wr && waddr == ADDR_NTR) |=> ntr_q == $past(wdata))
		else $error("falling mask write lost");
	a_event_set: assert property (@(posedge mclk_in) disable iff (rst_in)
		(ntr_q[6] && cond_q[6] && !cond_d[6]) |=> event_out[6])
		else $error("falling edge event not set");
	a_summary: assert property (@(posedge mclk_in) disable iff (rst_in)
		(|(hits & enab_q)) |=> status_byte_out[7])
		else $error("summary did not reach status byte");
	a_stb_cause: assert property (@(posedge mclk_in) disable iff (rst_in)
		$rose(status_byte_out[7]) |-> |(event_out & $past(enab_q)))
		else $error("bit 7 set without enabled event");
	a_trig_hold: assert property (@(posedge mclk_in) disable iff (rst_in)
		(state_q == OSR_WAIT_TRIG && trig_hold_in && !trig_imm_in)
		|=> !sample_out)
		else $error("sample taken while trigger held");
	a_event_sticky: assert property (@(posedge mclk_in) disable iff (rst_in)
		(event_q[6] && !clear_in && !event_rd_in) |=> event_out[6])
		else $error("event bit lost without clear");
	a_stb_clear: assert property (@(posedge mclk_in) disable iff (rst_in)
		(stb_rd_in && !(|(hits & enab_q))) |=> !status_byte_out[7])
		else $error("status bit 7 not cleared by read");
endmodule
`default_nettype wire

// ==== test/osr_host_model.sv ====
/*
 Host controller model: polls the status byte and reads it once the
 summary bit is set. Assumes it is clocked by the design clock.
*/
`timescale 1ns/1ps
`default_nettype none
module osr_host_model (
	input wire logic mclk_in,
	input wire logic poll_in,
	input wire logic [7:0] status_byte_in,
	output logic stb_rd_out,
	output logic armed_out
);
	always @(negedge mclk_in) begin
		stb_rd_out <= 1'b0;
		if (!poll_in) begin
			armed_out <= 1'b0;
		end
		if (poll_in && !stb_rd_out && status_byte_in[7]) begin
			stb_rd_out <= 1'b1;
			armed_out <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ==== test/osr_top_tb_top.sv ====
/*
 Testbench of the operation status block: reset defaults, both
 command paths, external and level arm, held trigger, read clears.
 Assumes osr_defs.svh is on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "osr_defs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
	$display("wrong value %s exp %h got %h", nm, e, g); end end
module osr_top_tb_top;
	logic mclk_in, rst_in, host_sel_in, msg_wr_in, reg_wr_in, init_in;
	logic trig_imm_in, clear_in, event_rd_in, stb_rd_in, ext_arm_in;
	logic arm_src_level_in, trig_hold_in, input_level_arm_source_in;
	logic poll, armed, sample_out;
	logic [1:0] msg_addr_in, reg_addr_in;
	logic [15:0] msg_data_in, reg_data_in, condition_out, event_out;
	logic [`OSR_LEVEL_W-1:0] arm_level_in;
	logic [7:0] status_byte_out;
	int fails = 0, n_tests = 0, samples = 0;
	int s0 = 0;
	osr_top u_osr_top (.mclk_in, .rst_in, .host_sel_in, .msg_wr_in,
		.msg_addr_in, .msg_data_in, .reg_wr_in, .reg_addr_in, .reg_data_in,
		.init_in, .trig_imm_in, .clear_in, .event_rd_in, .stb_rd_in,
		.arm_src_level_in, .trig_hold_in, .arm_level_in, .ext_arm_in,
		.input_level_arm_source_in, .condition_out, .event_out,
		.status_byte_out, .sample_out);
	osr_host_model u_osr_host_model (.mclk_in, .poll_in(poll),
		.status_byte_in(status_byte_out), .stb_rd_out(stb_rd_in),
		.armed_out(armed));
	initial begin
		mclk_in = 1'b0;
		forever #5 mclk_in = ~mclk_in;
	end
	always @(posedge mclk_in) if (sample_out === 1'b1) samples++;
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic wr(input logic sel, input logic [1:0] a,
		input logic [15:0] d);
		@(negedge mclk_in);
		host_sel_in = sel;
		reg_wr_in = sel;
		msg_wr_in = !sel;
		reg_addr_in = a;
		msg_addr_in = a;
		reg_data_in = d;
		msg_data_in = d;
		@(negedge mclk_in);
		reg_wr_in = 1'b0;
		msg_wr_in = 1'b0;
	endtask
	task automatic pulse(ref logic s);
		@(negedge mclk_in);
		s = 1'b1;
		@(negedge mclk_in);
		s = 1'b0;
	endtask
	// Bounded wait for the wait-for-arm bit
	task automatic wait_c(input logic v);
		int i;
		i = 0;
		while (condition_out[`OSR_WAIT_ARM_BIT] !== v && i < 40) begin
			@(negedge mclk_in);
			i++;
		end
		if (i == 40) begin
			fails++;
			complete_run();
		end
	endtask
	initial begin
		{host_sel_in, msg_wr_in, reg_wr_in, init_in, trig_imm_in} = '0;
		{clear_in, event_rd_in, ext_arm_in, arm_src_level_in} = '0;
		{trig_hold_in, input_level_arm_source_in, poll} = '0;
		{msg_addr_in, reg_addr_in, msg_data_in, reg_data_in} = '0;
		arm_level_in = '0;
		rst_in = 1'b1;
		repeat (5) @(negedge mclk_in);
		rst_in = 1'b0;
		pulse(init_in);
		`CHK("condition", 16'h0040, condition_out)
		`CHK("event", 16'h0040, event_out)
		`CHK("status", 8'h00, status_byte_out)
		pulse(event_rd_in);
		`CHK("event", 16'h0000, event_out)
		ext_arm_in = 1'b1;
		wait_c(1'b0);
		ext_arm_in = 1'b0;
		`CHK("event", 16'h0000, event_out)
		$display("test defaults done");
		wr(1'b0, 2'h1, 16'h0040);
		wr(1'b0, 2'h0, 16'h0000);
		wr(1'b1, 2'h2, 16'h0040);
		trig_hold_in = 1'b1;
		poll = 1'b1;
		s0 = samples;
		pulse(init_in);
		`CHK("condition", 16'h0040, condition_out)
		`CHK("event", 16'h0000, event_out)
		ext_arm_in = 1'b1;
		wait_c(1'b0);
		ext_arm_in = 1'b0;
		`CHK("condition", 16'h0000, condition_out)
		`CHK("event", 16'h0040, event_out)
		`CHK("status", 8'h80, status_byte_out)
		repeat (2) @(negedge mclk_in);
		`CHK("armed", 1'b1, armed)
		`CHK("status", 8'h00, status_byte_out)
		`CHK("samples", s0, samples)
		pulse(trig_imm_in);
		@(negedge mclk_in);
		`CHK("samples", s0 + 1, samples)
		$display("test held trigger done");
		arm_src_level_in = 1'b1;
		trig_hold_in = 1'b0;
		arm_level_in = 12'h4b0;
		s0 = samples;
		pulse(clear_in);
		`CHK("event", 16'h0000, event_out)
		`CHK("status", 8'h00, status_byte_out)
		pulse(init_in);
		input_level_arm_source_in = 1'b1;
		wait_c(1'b0);
		@(negedge mclk_in);
		input_level_arm_source_in = 1'b0;
		`CHK("event", 16'h0040, event_out)
		`CHK("sample", 1'b1, sample_out)
		@(negedge mclk_in);
		`CHK("samples", s0 + 1, samples)
		$display("test level arm done");
		rst_in = 1'b1;
		repeat (5) @(negedge mclk_in);
		rst_in = 1'b0;
		pulse(init_in);
		`CHK("event", 16'h0040, event_out)
		`CHK("status", 8'h00, status_byte_out)
		$display("test mid reset done");
		complete_run();
	end
endmodule
`default_nettype wire
